// *** hw/prd_pkg.sv ***
// Purpose: Constants for the range decode configuration block
// Assumes: Byte-addressed configuration offsets, 32-bit data path
// Notes: Offsets are the printed configuration addresses
package prd_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_MON13 = 8'h74;
	localparam logic [7:0] OFS_GEN0 = 8'h78;
	localparam logic [7:0] OFS_GEN1 = 8'h7c;
	localparam logic [7:0] OFS_PMMISC = 8'h80;
	// ==========================================================
	// Field positions
	localparam int MON13_BASE_LSB = 15;
	localparam int MON13_BASE_W = 17;
	localparam int MON13_EN_BIT = 7;
	localparam int MON13_MASK_LSB = 0;
	localparam int MON13_MASK_W = 7;
	localparam int MON13_MASK_ADDR_LSB = 15;
	localparam int GEN_BASE_LSB = 0;
	localparam int GEN_BASE_W = 16;
	localparam int GEN_MASK_LSB = 16;
	localparam int GEN_MASK_W = 4;
	localparam int GEN_EN_BIT = 20;
	localparam int PM_EN_BIT = 0;
	localparam int PM_SPACE_W = 6;
	// ==========================================================
	// Reset values
	localparam logic [31:0] MON13_RESET = 32'h0000_0000;
	localparam logic [31:0] GEN_RESET = 32'h0000_0000;
	localparam logic [7:0] PMMISC_RESET = 8'h00;
	// Writable bit masks, reserved bits stay zero
	localparam logic [31:0] MON13_WMASK = 32'hffff_80ff;
	localparam logic [31:0] GEN_WMASK = 32'h001f_ffff;
	localparam logic [7:0] PMMISC_WMASK = 8'h01;
endpackage : prd_pkg

// *** hw/prd_window_match.sv ***
// Purpose: Masked base compare for one address window
// Assumes: Mask bits map onto a contiguous slice of the address
// Notes: Mask applied bit by bit, split windows allowed
`timescale 1ns/1ps
module prd_window_match #(
	parameter int AW = 16,
	parameter int MW = 4,
	parameter int MLSB = 0
) (
	// Window setup
	input wire logic [AW-1:0] base,
	input wire logic [MW-1:0] mask,
	input wire logic enable,
	// Address under test
	input wire logic [AW-1:0] addr,
	// Result
	output logic hit
);
	logic [AW-1:0] ignore;
	always_comb begin
		ignore = '0;
		ignore[MLSB +: MW] = mask;
	end
	// No validity check on the mask: any pattern is taken literally
	assign hit = enable && (((addr ^ base) & ~ignore) == '0);
endmodule : prd_window_match

// *** hw/prd_decode_config.sv ***
// Purpose: Range decode registers and window matching for the power management function
// Assumes: Config, memory and I/O cycles are presented synchronously on clk
// Notes: Hit outputs are registered one cycle after the address strobe
`timescale 1ns/1ps
module prd_decode_config #(
	parameter int PM_SPACE_W = prd_pkg::PM_SPACE_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Configuration access
	input wire logic cfg_sel,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	// Qualifiers from elsewhere
	input wire logic mon13_eio_en,
	input wire logic mon13_trap_en,
	input wire logic [15:0] pm_io_base,
	// Bus address under decode
	input wire logic mem_strobe,
	input wire logic io_strobe,
	input wire logic [31:0] bus_addr,
	// Decode results
	output logic mon13_fwd_hit,
	output logic mon13_trap_hit,
	output logic generic_window0_claim,
	output logic generic_window1_claim,
	output logic pm_io_hit
);
	import prd_pkg::*;

	// ==========================================================
	// Access strobes
	logic wr_strobe;
	logic rd_strobe;

	assign wr_strobe = cfg_sel && cfg_wr;
	assign rd_strobe = cfg_sel && !cfg_wr;

	// ==========================================================
	// Offset decode
	logic hit_mon13;
	logic hit_gen0;
	logic hit_gen1;
	logic hit_pmmisc;

	// Unmapped offsets select nothing, so they write nothing and read zero
	always_comb begin
		hit_mon13 = 1'b0;
		hit_gen0 = 1'b0;
		hit_gen1 = 1'b0;
		hit_pmmisc = 1'b0;
		if (cfg_addr == OFS_MON13) begin
			hit_mon13 = 1'b1;
		end else if (cfg_addr == OFS_GEN0) begin
			hit_gen0 = 1'b1;
		end else if (cfg_addr == OFS_GEN1) begin
			hit_gen1 = 1'b1;
		end else if (cfg_addr == OFS_PMMISC) begin
			hit_pmmisc = 1'b1;
		end
	end

	// ==========================================================
	// Byte lanes
	logic [31:0] lane_mask;

	assign lane_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};

	// ==========================================================
	// Register storage
	logic [31:0] mon13_r;
	logic [31:0] mon13_nxt;
	logic [31:0] gen0_r;
	logic [31:0] gen0_nxt;
	logic [31:0] gen1_r;
	logic [31:0] gen1_nxt;
	logic [7:0] pmmisc_r;
	logic [7:0] pmmisc_nxt;

	// Reserved bits forced low on every write, never read back as one
	always_comb begin
		mon13_nxt = mon13_r;
		if (wr_strobe && hit_mon13) begin
			mon13_nxt = ((mon13_r & ~lane_mask) | (cfg_wdata & lane_mask)) & MON13_WMASK;
		end
	end

	always_comb begin
		gen0_nxt = gen0_r;
		if (wr_strobe && hit_gen0) begin
			gen0_nxt = ((gen0_r & ~lane_mask) | (cfg_wdata & lane_mask)) & GEN_WMASK;
		end
	end

	always_comb begin
		gen1_nxt = gen1_r;
		if (wr_strobe && hit_gen1) begin
			gen1_nxt = ((gen1_r & ~lane_mask) | (cfg_wdata & lane_mask)) & GEN_WMASK;
		end
	end

	// Only byte lane 0 exists at this offset
	always_comb begin
		pmmisc_nxt = pmmisc_r;
		if (wr_strobe && hit_pmmisc && cfg_be[0]) begin
			pmmisc_nxt = cfg_wdata[7:0] & PMMISC_WMASK;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mon13_r <= MON13_RESET;
		end else begin
			mon13_r <= mon13_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			gen0_r <= GEN_RESET;
		end else begin
			gen0_r <= gen0_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			gen1_r <= GEN_RESET;
		end else begin
			gen1_r <= gen1_nxt;
		end
	end

	// Software must load the PM base first; no interlock here
	always_ff @(posedge clk) begin
		if (reset) begin
			pmmisc_r <= PMMISC_RESET;
		end else begin
			pmmisc_r <= pmmisc_nxt;
		end
	end

	// ==========================================================
	// Read back
	logic [31:0] cfg_rdata_nxt;

	// Holds the last read so the host may sample it late
	always_comb begin
		cfg_rdata_nxt = cfg_rdata;
		if (rd_strobe) begin
			if (hit_mon13) begin
				cfg_rdata_nxt = mon13_r;
			end else if (hit_gen0) begin
				cfg_rdata_nxt = gen0_r;
			end else if (hit_gen1) begin
				cfg_rdata_nxt = gen1_r;
			end else if (hit_pmmisc) begin
				cfg_rdata_nxt = {24'h00_0000, pmmisc_r};
			end else begin
				cfg_rdata_nxt = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_rdata <= 32'h0000_0000;
		end else begin
			cfg_rdata <= cfg_rdata_nxt;
		end
	end

	// ==========================================================
	// Field extraction
	logic [MON13_BASE_W-1:0] mon13_mem_base;
	logic [MON13_MASK_W-1:0] mon13_mem_mask;
	logic mon13_mem_monitor_en;
	logic [GEN_BASE_W-1:0] generic_window0_base;
	logic [GEN_MASK_W-1:0] generic_window0_mask;
	logic generic_window0_en;
	logic [GEN_BASE_W-1:0] generic_window1_base;
	logic [GEN_MASK_W-1:0] generic_window1_mask;
	logic generic_window1_en;
	logic pm_io_space_en;

	assign mon13_mem_base = mon13_r[MON13_BASE_LSB +: MON13_BASE_W];
	assign mon13_mem_mask = mon13_r[MON13_MASK_LSB +: MON13_MASK_W];
	assign mon13_mem_monitor_en = mon13_r[MON13_EN_BIT];
	assign generic_window0_base = gen0_r[GEN_BASE_LSB +: GEN_BASE_W];
	assign generic_window0_mask = gen0_r[GEN_MASK_LSB +: GEN_MASK_W];
	assign generic_window0_en = gen0_r[GEN_EN_BIT];
	assign generic_window1_base = gen1_r[GEN_BASE_LSB +: GEN_BASE_W];
	assign generic_window1_mask = gen1_r[GEN_MASK_LSB +: GEN_MASK_W];
	assign generic_window1_en = gen1_r[GEN_EN_BIT];
	assign pm_io_space_en = pmmisc_r[PM_EN_BIT];

	// ==========================================================
	// Window compares
	logic mon13_match;
	logic gen0_match;
	logic gen1_match;

	// Mask slice sits at address bit 21:15, i.e. mask index 0 of the 17-bit field
	prd_window_match #(
		.AW(MON13_BASE_W),
		.MW(MON13_MASK_W),
		.MLSB(0)
	) u_mon13 (
		.base(mon13_mem_base),
		.mask(mon13_mem_mask),
		.enable(mon13_mem_monitor_en),
		.addr(bus_addr[31:MON13_MASK_ADDR_LSB]),
		.hit(mon13_match)
	);

	prd_window_match #(
		.AW(GEN_BASE_W),
		.MW(GEN_MASK_W),
		.MLSB(0)
	) u_gen0 (
		.base(generic_window0_base),
		.mask(generic_window0_mask),
		.enable(generic_window0_en),
		.addr(bus_addr[15:0]),
		.hit(gen0_match)
	);

	prd_window_match #(
		.AW(GEN_BASE_W),
		.MW(GEN_MASK_W),
		.MLSB(0)
	) u_gen1 (
		.base(generic_window1_base),
		.mask(generic_window1_mask),
		.enable(generic_window1_en),
		.addr(bus_addr[15:0]),
		.hit(gen1_match)
	);

	// PM block covers the fixed aligned span that contains the programmed base
	logic pm_match;
	assign pm_match = (bus_addr[15:PM_SPACE_W] == pm_io_base[15:PM_SPACE_W]);

	// ==========================================================
	// Decode qualifiers
	logic mon13_fwd_nxt;
	logic mon13_trap_nxt;
	logic gen0_claim_nxt;
	logic gen1_claim_nxt;
	logic pm_hit_nxt;

	// Monitor window alone never hits; an outside enable must agree
	always_comb begin
		mon13_fwd_nxt = mem_strobe && mon13_match && mon13_eio_en;
	end

	always_comb begin
		mon13_trap_nxt = mem_strobe && mon13_match && mon13_trap_en;
	end

	// Strobe type is the only cycle qualifier; no command decode here
	always_comb begin
		gen0_claim_nxt = io_strobe && gen0_match;
	end

	always_comb begin
		gen1_claim_nxt = io_strobe && gen1_match;
	end

	// Function I/O enable deliberately not an input: the two do not gate each other
	always_comb begin
		pm_hit_nxt = io_strobe && pm_match && pm_io_space_en;
	end

	// ==========================================================
	// Registered decode results
	// Each hit follows its strobe by exactly one cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			mon13_fwd_hit <= 1'b0;
		end else begin
			mon13_fwd_hit <= mon13_fwd_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mon13_trap_hit <= 1'b0;
		end else begin
			mon13_trap_hit <= mon13_trap_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			generic_window0_claim <= 1'b0;
		end else begin
			generic_window0_claim <= gen0_claim_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			generic_window1_claim <= 1'b0;
		end else begin
			generic_window1_claim <= gen1_claim_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pm_io_hit <= 1'b0;
		end else begin
			pm_io_hit <= pm_hit_nxt;
		end
	end
endmodule : prd_decode_config

// *** testbench/prd_decode_config_properties.sv ***
// Purpose: Port-level properties for the range decoder
// Assumes: Hits registered one cycle after a strobe
// Notes: PM block size follows PM_SPACE_W
`timescale 1ns/1ps
module prd_decode_props #(
	parameter int PM_SPACE_W = 6
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Config
	input wire logic cfg_sel,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_rdata,
	// Decode
	input wire logic mon13_eio_en,
	input wire logic mon13_trap_en,
	input wire logic [15:0] pm_io_base,
	input wire logic mem_strobe,
	input wire logic io_strobe,
	input wire logic [31:0] bus_addr,
	input wire logic mon13_fwd_hit,
	input wire logic mon13_trap_hit,
	input wire logic generic_window0_claim,
	input wire logic generic_window1_claim,
	input wire logic pm_io_hit
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_rst;
		disable iff (1'b0) reset |=> !pm_io_hit && !mon13_fwd_hit && cfg_rdata == 32'h0000_0000;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	property p_rsv;
		cfg_sel && !cfg_wr && cfg_addr == 8'h80 |=> cfg_rdata[31:1] == 31'h0000_0000;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
	property p_pm;
		pm_io_hit |-> $past(io_strobe);
	endproperty
	a_pm: assert property (p_pm) else $error("pm hit without io cycle");
	property p_pmb;
		pm_io_hit |-> $past(bus_addr[15:PM_SPACE_W]) == $past(pm_io_base[15:PM_SPACE_W]);
	endproperty
	a_pmb: assert property (p_pmb) else $error("pm hit outside pm block");
	property p_gen0;
		generic_window0_claim |-> $past(io_strobe);
	endproperty
	a_gen0: assert property (p_gen0) else $error("window 0 claim without io cycle");
	property p_gen1;
		generic_window1_claim |-> $past(io_strobe);
	endproperty
	a_gen1: assert property (p_gen1) else $error("window 1 claim without io cycle");
	property p_fwd;
		mon13_fwd_hit |-> $past(mem_strobe) && $past(mon13_eio_en);
	endproperty
	a_fwd: assert property (p_fwd) else $error("forward hit without qualifier");
	property p_trap;
		mon13_trap_hit |-> $past(mem_strobe) && $past(mon13_trap_en);
	endproperty
	a_trap: assert property (p_trap) else $error("trap hit without qualifier");
	c_gen0: cover property (generic_window0_claim);
	c_fwd: cover property (mon13_fwd_hit);
	c_pm: cover property (pm_io_hit);
endmodule : prd_decode_props

bind prd_decode_config prd_decode_props #(.PM_SPACE_W(PM_SPACE_W)) u_props (.clk(clk), .reset(reset),
	.cfg_sel(cfg_sel), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
	.mon13_eio_en(mon13_eio_en), .mon13_trap_en(mon13_trap_en), .pm_io_base(pm_io_base),
	.mem_strobe(mem_strobe), .io_strobe(io_strobe), .bus_addr(bus_addr),
	.mon13_fwd_hit(mon13_fwd_hit), .mon13_trap_hit(mon13_trap_hit),
	.generic_window0_claim(generic_window0_claim), .generic_window1_claim(generic_window1_claim),
	.pm_io_hit(pm_io_hit));

// *** testbench/prd_host_model.sv ***
// Purpose: Host bridge issuing config, memory and I/O cycles
// Assumes: One-cycle requests launched at the falling edge
// Notes: Released cfg_wdata and bus_addr are inverted; cfg_wr, cfg_addr and cfg_be keep their last value
`timescale 1ns/1ps
module prd_host_model (
	// Clock
	input wire logic clk,
	// Requests
	output logic cfg_sel = 1'b0,
	output logic cfg_wr = 1'b0,
	output logic [7:0] cfg_addr = 8'h00,
	output logic [3:0] cfg_be = 4'h0,
	output logic [31:0] cfg_wdata = 32'h0000_0000,
	output logic mem_strobe = 1'b0,
	output logic io_strobe = 1'b0,
	output logic [31:0] bus_addr = 32'h0000_0000
);
	// ==========================================================
	// Cycles
	task cfg(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b = 4'hf);
		@(negedge clk);
		cfg_sel = 1'b1;
		cfg_wr = w;
		cfg_addr = a;
		cfg_be = b;
		cfg_wdata = d;
		@(negedge clk);
		cfg_sel = 1'b0;
		cfg_wdata = ~d;
	endtask : cfg
	task cyc(input logic m, input logic [31:0] a);
		@(negedge clk);
		mem_strobe = m;
		io_strobe = !m;
		bus_addr = a;
		@(negedge clk);
		mem_strobe = 1'b0;
		io_strobe = 1'b0;
		bus_addr = ~a;
	endtask : cyc
endmodule : prd_host_model

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the range decode block
// Assumes: Reads and hits sampled one cycle after the request
// Notes: Function I/O enable has no port here, so only indirect
`timescale 1ns/1ps
module testbench;
	import prd_pkg::*;
	logic clk, reset, extended_io_bus = 1'b0, trap = 1'b0;
	logic [15:0] pm_base = 16'h0000;
	logic sel, wr, mst, ist, fwd, trh, g0, g1, pmh;
	logic [7:0] addr;
	logic [3:0] be;
	logic [31:0] wd, rd_q, ba;
	int miscompares = 0, n_checks = 0;
	prd_host_model u_host (.clk(clk), .cfg_sel(sel), .cfg_wr(wr), .cfg_addr(addr), .cfg_be(be),
		.cfg_wdata(wd), .mem_strobe(mst), .io_strobe(ist), .bus_addr(ba));
	prd_decode_config u_dut (.clk(clk), .reset(reset), .cfg_sel(sel), .cfg_wr(wr), .cfg_addr(addr),
		.cfg_be(be), .cfg_wdata(wd), .cfg_rdata(rd_q), .mon13_eio_en(extended_io_bus), .mon13_trap_en(trap),
		.pm_io_base(pm_base), .mem_strobe(mst), .io_strobe(ist), .bus_addr(ba), .mon13_fwd_hit(fwd),
		.mon13_trap_hit(trh), .generic_window0_claim(g0), .generic_window1_claim(g1), .pm_io_hit(pmh));
	// ==========================================================
	// Helpers
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task rd(input logic [7:0] a, input logic [31:0] e);
		u_host.cfg(1'b0, a, 32'h0000_0000);
		chk("cfg_rdata", e, rd_q);
	endtask : rd
	task io_chk(input logic [31:0] a, input logic [2:0] e);
		u_host.cyc(1'b0, a);
		chk("io claims", {29'h0000_0000, e}, {29'h0000_0000, g0, g1, pmh});
	endtask : io_chk
	task mem_chk(input logic [31:0] a, input logic [1:0] e);
		u_host.cyc(1'b1, a);
		chk("mem hits", {30'h0000_0000, e}, {30'h0000_0000, fwd, trh});
	endtask : mem_chk
	task tally_and_finish;
		if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	// ==========================================================
	// Scenarios
	task t_regs;
		rd(OFS_MON13, 32'h0000_0000);
		rd(OFS_PMMISC, 32'h0000_0000);
		u_host.cfg(1'b1, OFS_MON13, '1);
		rd(OFS_MON13, 32'hffff_80ff);
		u_host.cfg(1'b1, OFS_MON13, 32'h0000_0000, 4'h1);
		rd(OFS_MON13, 32'hffff_8000);
		u_host.cfg(1'b1, OFS_GEN0, '1);
		rd(OFS_GEN0, 32'h001f_ffff);
		u_host.cfg(1'b1, OFS_GEN1, '1);
		rd(OFS_GEN1, 32'h001f_ffff);
		u_host.cfg(1'b1, OFS_PMMISC, '1);
		rd(OFS_PMMISC, 32'h0000_0001);
		u_host.cfg(1'b1, OFS_PMMISC, 32'h0000_0000, 4'he);
		rd(OFS_PMMISC, 32'h0000_0001);
		u_host.cfg(1'b1, 8'h84, '1);
		rd(8'h84, 32'h0000_0000);
	endtask : t_regs
	task t_gen;
		u_host.cfg(1'b1, OFS_GEN0, 32'h0019_0120);
		u_host.cfg(1'b1, OFS_GEN1, 32'h0010_2f05);
		io_chk(32'h0000_0120, 3'b100);
		io_chk(32'h0000_0129, 3'b100);
		io_chk(32'h0000_0122, 3'b000);
		io_chk(32'h0000_2f05, 3'b010);
		io_chk(32'h0000_2f04, 3'b000);
		u_host.cfg(1'b1, OFS_GEN0, 32'h0009_0120);
		io_chk(32'h0000_0120, 3'b000);
		u_host.cfg(1'b1, OFS_GEN1, 32'h0000_2f05);
		io_chk(32'h0000_2f05, 3'b000);
	endtask : t_gen
	task t_mon;
		u_host.cfg(1'b1, OFS_MON13, 32'h8000_00f3);
		extended_io_bus = 1'b1;
		mem_chk(32'h8000_0000, 2'b10);
		mem_chk(32'h8038_8000, 2'b10);
		mem_chk(32'h8002_0000, 2'b00);
		mem_chk(32'h0000_0000, 2'b00);
		extended_io_bus = 1'b0;
		trap = 1'b1;
		mem_chk(32'h8000_7fff, 2'b01);
		trap = 1'b0;
		mem_chk(32'h8000_0000, 2'b00);
		extended_io_bus = 1'b1;
		u_host.cfg(1'b1, OFS_MON13, 32'h8000_0073);
		mem_chk(32'h8000_0000, 2'b00);
		extended_io_bus = 1'b0;
	endtask : t_mon
	task t_pm;
		pm_base = 16'h0400; // Base set before the enable
		u_host.cfg(1'b1, OFS_PMMISC, 32'h0000_0000);
		io_chk(32'h0000_0410, 3'b000);
		u_host.cfg(1'b1, OFS_PMMISC, 32'h0000_0001);
		io_chk(32'h0000_0410, 3'b001);
		io_chk(32'h0000_0440, 3'b000);
	endtask : t_pm
	// ==========================================================
	// Run
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (2000) @(posedge clk);
		miscompares++;
		tally_and_finish;
	end
	initial begin
		reset = 1'b1;
		repeat (8) @(negedge clk);
		reset = 1'b0;
		t_regs;
		t_gen;
		t_mon;
		t_pm;
		tally_and_finish;
	end
endmodule : testbench
